// [verilog/pic_pkg.sv]
// pic_pkg: constants, state encodings and helpers of the interrupt core.
// assumes single clock domain; bus strobes arrive as one-cycle pulses.
// Summary of operation
// - master slave-map marks cascaded request inputs
// - slave compares id bits with cascade lines
// - master gives call byte, slave later bytes
// - special-nesting bit enables special nested mode
// - buffer bit makes pin output, master-select used
// - auto end clears at final acknowledge pulse end
// - processor-mode bit picks call or vector mode
// - mask bit one disables its input only
// - rotate/select-level/end bits encode commands
// - enable bit gates special mask mode change
// - after init input zero highest, seven lowest
// - acknowledge sets in-service until end command
// - in-service blocks equal and lower priority
// - non-specific end clears highest in-service
// - specific end clears named level's in-service
// - special mask: non-specific end skips masked
// - rotation makes serviced level the lowest
// - set-priority names lowest level independently
// - special mask enables all unmasked levels
// - poll makes next read an acknowledge
// - poll word: flag, zeros, level code
// - first init word resets mask, priority, modes
// - read-register bit selects request or in-service
// - level-trigger bit picks edge or level sense
package pic_pkg;

   localparam int          PIC_LEVELS     = 8;
   // first init word
   localparam int          INIT_SEL_BIT   = 4;
   localparam int          IC4_BIT        = 0;
   localparam int          SNGL_BIT       = 1;
   localparam int          ADI_BIT        = 2;
   localparam int          LEVEL_TRIGGER_BIT_BIT       = 3;
   // fourth config word
   localparam int          UPM_BIT        = 0;
   localparam int          AUTO_END_BIT_BIT       = 1;
   localparam int          MS_BIT         = 2;
   localparam int          BUF_BIT        = 3;
   localparam int          SPECIAL_NESTING_BIT_BIT       = 4;
   // operation words
   localparam int          SPECIAL_MASK_POLL_COMMAND_SEL_BIT   = 3;
   localparam int          SPECIAL_MASK_ENABLE_BIT_BIT       = 6;
   localparam int          SMM_BIT        = 5;
   localparam int          POLL_BIT       = 2;
   localparam int          RR_BIT         = 1;
   localparam int          RIS_BIT        = 0;
   // rotate, select-level, end-of-service codes
   localparam logic [2:0]  CMD_NS_EOI     = 3'h1;
   localparam logic [2:0]  CMD_SP_EOI     = 3'h3;
   localparam logic [2:0]  CMD_ROT_NS     = 3'h5;
   localparam logic [2:0]  CMD_ROT_AUTO_END_BIT_S = 3'h4;
   localparam logic [2:0]  CMD_ROT_AUTO_END_BIT_C = 3'h0;
   localparam logic [2:0]  CMD_ROT_SP     = 3'h7;
   localparam logic [2:0]  CMD_SET_PRI    = 3'h6;
   // reset values, default level and fixed codes
   localparam logic [7:0]  MASK_RST       = 8'h00;
   localparam logic [2:0]  LOW_PRI_RST    = 3'h7;
   localparam logic [7:0]  SLAVE_MAP_RST  = 8'h07;
   localparam logic [2:0]  DEFAULT_LEVEL  = 3'h7;
   localparam logic [7:0]  CALL_OPCODE    = 8'hCD;
   localparam logic [1:0]  ACK_LAST_CALL  = 2'h3;
   localparam logic [1:0]  ACK_LAST_VEC   = 2'h2;

   typedef enum logic [3:0] {
      PIC_READY = 4'h1,
      PIC_WAIT2 = 4'h2,
      PIC_WAIT3 = 4'h4,
      PIC_WAIT4 = 4'h8
   } pic_init_t;

   // priority rank, 0 is highest
   function automatic logic [2:0] picRank(input logic [2:0] lvl,
                                          input logic [2:0] low);
      picRank = 3'(lvl - low - 3'h1);
   endfunction

   function automatic logic [7:0] picOneHot(input logic [2:0] lvl);
      picOneHot = 8'(8'h01 << lvl);
   endfunction

endpackage

// [verilog/pic_prio_pick.sv]
// pic_prio_pick: finds the highest-priority set bit of a level vector.
// assumes lowPri names the current lowest level; purely combinational.
module pic_prio_pick
   import pic_pkg::*;
(
   input  wire logic [7:0] vec,
   input  wire logic [2:0] lowPri,
   output logic            found,
   output logic [2:0]      level
);

   always_comb begin
      logic [2:0] idx;
      idx   = 3'h0;
      found = 1'b0;
      level = 3'h0;
      // scan from highest rank downward
      for (int k = 0; k < PIC_LEVELS; k++) begin
         idx = 3'(lowPri + 3'h1 + 3'(k));
         if (!found && vec[idx]) begin
            found = 1'b1;
            level = idx;
         end
      end
   end

endmodule

// [verilog/pic_req_latch.sv]
// pic_req_latch: synchronises request pins and holds the request register.
// assumes request pins are asynchronous; clears come from the same clock.
module pic_req_latch
   import pic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] irqPin,
   input  wire logic       levelMode,
   input  wire logic       rearm,
   input  wire logic       freeze,
   input  wire logic [7:0] clrMask,
   output logic      [7:0] request_register
);

   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] prev;
      logic [7:0] request_register;
   } pic_req_t;

   pic_req_t st_ff;
   pic_req_t nxt_st;

   always_comb begin
      logic [7:0] rise;
      rise         = st_ff.sync2 & ~st_ff.prev;
      nxt_st       = st_ff;
      nxt_st.sync1 = irqPin;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.request_register   = st_ff.request_register & ~clrMask;
      if (!freeze) begin
         nxt_st.prev = st_ff.sync2;
         if (levelMode)
            nxt_st.request_register = st_ff.sync2;
         else
            nxt_st.request_register = (nxt_st.request_register | rise) & st_ff.sync2;
      end
      // edge sense needs a fresh low-to-high after init
      if (rearm) begin
         nxt_st.prev = 8'hFF;
         nxt_st.request_register  = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '{sync1: 8'h00, sync2: 8'h00, prev: 8'hFF, request_register: 8'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign request_register = st_ff.request_register;

endmodule

// [verilog/pic_core.sv]
// pic_core: eight-level priority interrupt controller, device side.
// assumes host strobes are synchronous one-cycle pulses; ackStrobe is a
// synchronous level held high for each acknowledge pulse.
module pic_core
   import pic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cs,
   input  wire logic       wrStrobe,
   input  wire logic       rdStrobe,
   input  wire logic       addr0,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] dataOut,
   output logic            dataOe,
   input  wire logic       ackStrobe,
   input  wire logic [7:0] irqPin,
   input  wire logic [2:0] casIn,
   output logic      [2:0] casOut,
   output logic            casOe,
   input  wire logic       spEnIn,
   output logic            spEnOut_n,
   output logic            spEnOe,
   output logic            intOut
);

   typedef struct packed {
      pic_init_t  initSt;
      logic       level_trigger_bit;
      logic       adi;
      logic       sngl;
      logic       ic4;
      logic [2:0] vecLoTop;
      logic [7:0] vecHi;
      logic [7:0] slaveMap;
      logic       special_nesting_bit;
      logic       bufMode;
      logic       msSel;
      logic       auto_end_bit;
      logic       upm;
      logic [7:0] mask_register;
      logic [7:0] in_service_register;
      logic [2:0] lowPri;
      logic       rotAeoi;
      logic       special_mask_bit;
      logic       readIsr;
      logic       pollPend;
      logic [1:0] ackCnt;
      logic       ackPrev;
      logic [2:0] ackLvl;
      logic       ackReal;
      logic       ackMine;
      logic       casDrive;
      logic       spSync1;
      logic       spSync2;
      logic [2:0] casSync1;
      logic [2:0] casSync2;
      logic [7:0] dOut;
      logic       dOe;
      logic [2:0] casO;
      logic       casE;
      logic       spEnO_n;
      logic       spEnE;
      logic       intO;
   } pic_core_t;

   pic_core_t  st_ff;
   pic_core_t  nxt_st;

   logic [7:0] request_register;
   logic [7:0] irrClr;
   logic       rearm;
   logic       freeze;
   logic       reqFound;
   logic [2:0] reqLvl;
   logic       isrFound;
   logic [2:0] isrLvl;
   logic [7:0] isrEff;

   pic_req_latch u_req (
      .clk       (clk),
      .rst       (rst),
      .irqPin    (irqPin),
      .levelMode (st_ff.level_trigger_bit),
      .rearm     (rearm),
      .freeze    (freeze),
      .clrMask   (irrClr),
      .request_register       (request_register)
   );

   pic_prio_pick u_req_pick (
      .vec    (request_register & ~st_ff.mask_register),
      .lowPri (st_ff.lowPri),
      .found  (reqFound),
      .level  (reqLvl)
   );

   // masked in-service bits are invisible under special mask
   assign isrEff = st_ff.in_service_register & ~(st_ff.special_mask_bit ? st_ff.mask_register : 8'h00);

   pic_prio_pick u_isr_pick (
      .vec    (isrEff),
      .lowPri (st_ff.lowPri),
      .found  (isrFound),
      .level  (isrLvl)
   );

   // requests are frozen while polled or acknowledged
   assign freeze = st_ff.pollPend | (st_ff.ackCnt != 2'h0) | ackStrobe;

   always_comb begin
      logic       isMaster;
      logic       isSlave;
      logic       wrHit;
      logic       rdHit;
      logic       ackStart;
      logic       ackEnd;
      logic [1:0] ackLast;
      logic [1:0] ackNum;
      logic [2:0] cmd;
      logic [2:0] lvl;
      logic [7:0] isrSet;
      logic [7:0] isrClr;
      logic [2:0] rReq;
      logic [2:0] rIsr;
      logic       intCond;
      nxt_st   = st_ff;
      isrSet   = 8'h00;
      isrClr   = 8'h00;
      irrClr   = 8'h00;
      rearm    = 1'b0;
      wrHit    = cs & wrStrobe;
      rdHit    = cs & rdStrobe;
      ackStart = ackStrobe & ~st_ff.ackPrev;
      ackEnd   = ~ackStrobe & st_ff.ackPrev;
      ackLast  = st_ff.upm ? ACK_LAST_VEC : ACK_LAST_CALL;
      ackNum   = 2'(st_ff.ackCnt + 2'h1);
      cmd      = dataIn[7:5];
      lvl      = dataIn[2:0];
      rReq     = picRank(reqLvl, st_ff.lowPri);
      rIsr     = picRank(isrLvl, st_ff.lowPri);

      nxt_st.spSync1  = spEnIn;
      nxt_st.spSync2  = st_ff.spSync1;
      nxt_st.casSync1 = casIn;
      nxt_st.casSync2 = st_ff.casSync1;
      nxt_st.ackPrev  = ackStrobe;

      // master-select counts only in buffered mode
      isMaster = st_ff.bufMode ? st_ff.msSel : st_ff.spSync2;
      isSlave  = ~st_ff.sngl & ~isMaster;

      // register writes
      if (wrHit && !addr0 && dataIn[INIT_SEL_BIT]) begin
         nxt_st.initSt   = PIC_WAIT2;
         nxt_st.ic4      = dataIn[IC4_BIT];
         nxt_st.sngl     = dataIn[SNGL_BIT];
         nxt_st.adi      = dataIn[ADI_BIT];
         nxt_st.level_trigger_bit     = dataIn[LEVEL_TRIGGER_BIT_BIT];
         nxt_st.vecLoTop = dataIn[7:5];
         nxt_st.mask_register      = MASK_RST;
         nxt_st.lowPri   = LOW_PRI_RST;
         nxt_st.slaveMap = SLAVE_MAP_RST;
         nxt_st.special_mask_bit      = 1'b0;
         nxt_st.readIsr  = 1'b0;
         nxt_st.rotAeoi  = 1'b0;
         nxt_st.pollPend = 1'b0;
         rearm           = 1'b1;
         if (!dataIn[IC4_BIT]) begin
            nxt_st.special_nesting_bit    = 1'b0;
            nxt_st.bufMode = 1'b0;
            nxt_st.msSel   = 1'b0;
            nxt_st.auto_end_bit    = 1'b0;
            nxt_st.upm     = 1'b0;
         end
      end else if (wrHit && !addr0 && dataIn[SPECIAL_MASK_POLL_COMMAND_SEL_BIT]) begin
         if (dataIn[SPECIAL_MASK_ENABLE_BIT_BIT])
            nxt_st.special_mask_bit = dataIn[SMM_BIT];
         if (dataIn[POLL_BIT])
            nxt_st.pollPend = 1'b1;
         else if (dataIn[RR_BIT])
            nxt_st.readIsr = dataIn[RIS_BIT];
      end else if (wrHit && !addr0) begin
         case (cmd)
            CMD_NS_EOI, CMD_ROT_NS: begin
               if (isrFound) begin
                  isrClr = picOneHot(isrLvl);
                  if (cmd == CMD_ROT_NS)
                     nxt_st.lowPri = isrLvl;
               end
            end
            CMD_SP_EOI, CMD_ROT_SP: begin
               isrClr = picOneHot(lvl);
               if (cmd == CMD_ROT_SP)
                  nxt_st.lowPri = lvl;
            end
            CMD_SET_PRI:    nxt_st.lowPri  = lvl;
            CMD_ROT_AUTO_END_BIT_S: nxt_st.rotAeoi = 1'b1;
            CMD_ROT_AUTO_END_BIT_C: nxt_st.rotAeoi = 1'b0;
            default:        nxt_st.rotAeoi = st_ff.rotAeoi;
         endcase
      end else if (wrHit) begin
         case (st_ff.initSt)
            PIC_WAIT2: begin
               nxt_st.vecHi = dataIn;
               if (!st_ff.sngl)
                  nxt_st.initSt = PIC_WAIT3;
               else
                  nxt_st.initSt = st_ff.ic4 ? PIC_WAIT4 : PIC_READY;
            end
            PIC_WAIT3: begin
               nxt_st.slaveMap = dataIn;
               nxt_st.initSt   = st_ff.ic4 ? PIC_WAIT4 : PIC_READY;
            end
            PIC_WAIT4: begin
               nxt_st.special_nesting_bit    = dataIn[SPECIAL_NESTING_BIT_BIT];
               nxt_st.bufMode = dataIn[BUF_BIT];
               nxt_st.msSel   = dataIn[MS_BIT];
               nxt_st.auto_end_bit    = dataIn[AUTO_END_BIT_BIT];
               nxt_st.upm     = dataIn[UPM_BIT];
               nxt_st.initSt  = PIC_READY;
            end
            PIC_READY: nxt_st.mask_register = dataIn;
            default:   nxt_st.initSt = PIC_READY;
         endcase
      end

      // register reads, data valid the cycle after the strobe
      nxt_st.dOe = 1'b0;
      if (rdHit) begin
         nxt_st.dOe = 1'b1;
         if (st_ff.pollPend) begin
            nxt_st.pollPend = 1'b0;
            nxt_st.dOut = {reqFound, 4'h0, reqFound ? reqLvl : 3'h0};
            if (reqFound) begin
               isrSet = picOneHot(reqLvl);
               irrClr = picOneHot(reqLvl);
            end
         end else if (addr0)
            nxt_st.dOut = st_ff.mask_register;
         else
            nxt_st.dOut = st_ff.readIsr ? st_ff.in_service_register : request_register;
      end

      // acknowledge pulse sequence
      if (ackStart) begin
         nxt_st.ackCnt = ackNum;
         if (st_ff.ackCnt == 2'h0) begin
            nxt_st.ackLvl   = reqFound ? reqLvl : DEFAULT_LEVEL;
            nxt_st.ackReal  = reqFound;
            nxt_st.ackMine  = ~isSlave;
            nxt_st.casDrive = ~st_ff.sngl & isMaster & reqFound
                              & st_ff.slaveMap[reqLvl];
            if (!isSlave && reqFound) begin
               isrSet = picOneHot(reqLvl);
               irrClr = picOneHot(reqLvl);
            end
         end else if (st_ff.ackCnt == 2'h1 && isSlave
                      && st_ff.casSync2 == st_ff.slaveMap[2:0]) begin
            nxt_st.ackMine = 1'b1;
            if (st_ff.ackReal) begin
               isrSet = picOneHot(st_ff.ackLvl);
               irrClr = picOneHot(st_ff.ackLvl);
            end
         end
      end

      // data byte for the pulse just begun
      if (ackStart && ackNum <= ackLast) begin
         if (!isSlave && ackNum == 2'h1) begin
            nxt_st.dOe  = ~st_ff.upm;
            nxt_st.dOut = CALL_OPCODE;
         end else if (!isSlave && !nxt_st.casDrive) begin
            nxt_st.dOe  = 1'b1;
            nxt_st.dOut = vecByte(ackNum, nxt_st.ackLvl);
         end else if (isSlave && nxt_st.ackMine) begin
            nxt_st.dOe  = 1'b1;
            nxt_st.dOut = vecByte(ackNum, nxt_st.ackLvl);
         end
      end else if (ackStrobe && st_ff.dOe && !rdHit) begin
         nxt_st.dOe = 1'b1;
      end

      if (ackEnd && st_ff.ackCnt == 2'h1 && st_ff.casDrive)
         nxt_st.casO = st_ff.ackLvl;
      if (ackEnd && st_ff.ackCnt == ackLast) begin
         nxt_st.ackCnt   = 2'h0;
         nxt_st.casO     = 3'h0;
         nxt_st.casDrive = 1'b0;
         nxt_st.ackMine  = 1'b0;
         if (st_ff.auto_end_bit && isrFound) begin
            isrClr = isrClr | picOneHot(isrLvl);
            if (st_ff.rotAeoi)
               nxt_st.lowPri = isrLvl;
         end
      end
      nxt_st.casE = ~st_ff.sngl & isMaster;

      // set beats clear when both land together
      nxt_st.in_service_register = (st_ff.in_service_register & ~isrClr) | isrSet;

      // interrupt when nothing equal or higher is in service; special nesting lets equal through, special mask lets all
      intCond = reqFound & (st_ff.special_mask_bit
                | ~isrFound
                | (rReq < rIsr)
                | (st_ff.special_nesting_bit & (rReq == rIsr)));
      nxt_st.intO    = intCond;
      nxt_st.spEnE   = st_ff.bufMode;
      nxt_st.spEnO_n = ~nxt_st.dOe;
   end

   // byte 2 and 3 of call sequence, or the vector in vector mode
   function automatic logic [7:0] vecByte(input logic [1:0] num,
                                          input logic [2:0] l);
      if (st_ff.upm)
         vecByte = {st_ff.vecHi[7:3], l};
      else if (num == 2'h3)
         vecByte = st_ff.vecHi;
      else if (st_ff.adi)
         vecByte = {st_ff.vecLoTop, l, 2'h0};
      else
         vecByte = {st_ff.vecLoTop[2:1], l, 3'h0};
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff          <= '0;
         st_ff.initSt   <= PIC_READY;
         st_ff.mask_register      <= MASK_RST;
         st_ff.lowPri   <= LOW_PRI_RST;
         st_ff.slaveMap <= SLAVE_MAP_RST;
         st_ff.spEnO_n  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dataOut   = st_ff.dOut;
   assign dataOe    = st_ff.dOe;
   assign casOut    = st_ff.casO;
   assign casOe     = st_ff.casE;
   assign spEnOut_n = st_ff.spEnO_n;
   assign spEnOe    = st_ff.spEnE;
   assign intOut    = st_ff.intO;

endmodule

// [tb/pic_core_monitor.sv]
// pic_core_monitor: port-level checks of the interrupt core.
// assumes one clock and a synchronous active-high reset; bound below.
module pic_core_monitor
   import pic_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       cs,
   input wire logic       wrStrobe,
   input wire logic       rdStrobe,
   input wire logic       addr0,
   input wire logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic       dataOe,
   input wire logic       ackStrobe,
   input wire logic [7:0] irqPin,
   input wire logic [2:0] casOut,
   input wire logic       casOe,
   input wire logic       spEnOut_n,
   input wire logic       spEnOe,
   input wire logic       intOut
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] mk;
   logic       need2, need3, need4, bufSh, pollSh, rdReq;

   assign rdReq = cs && rdStrobe;

   // shadow of mask, init progress, buffered bit and pending poll
   always_ff @(posedge clk) begin
      if (rst) begin
         mk <= MASK_RST;
         {need2, need3, need4, bufSh, pollSh} <= 5'h00;
      end else if (cs && wrStrobe && !addr0) begin
         if (dataIn[INIT_SEL_BIT]) begin
            mk <= 8'h00;
            need2 <= 1'b1;
            need3 <= !dataIn[SNGL_BIT];
            need4 <= dataIn[IC4_BIT];
            bufSh <= 1'b0;
            pollSh <= 1'b0;
         end else if (dataIn[SPECIAL_MASK_POLL_COMMAND_SEL_BIT])
            pollSh <= dataIn[POLL_BIT];
      end else if (cs && wrStrobe) begin
         if (need2)
            need2 <= 1'b0;
         else if (need3)
            need3 <= 1'b0;
         else if (need4) begin
            need4 <= 1'b0;
            bufSh <= dataIn[BUF_BIT];
         end else
            mk <= dataIn;
      end else if (rdReq)
         pollSh <= 1'b0;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_RD_LAT: assert property (rdReq |=> dataOe)
      else $error("read data not driven");
   AST_POLL_FMT: assert property (rdReq && pollSh |=> dataOe &&
      dataOut[6:3] == 4'h0 && (dataOut[7] || dataOut == 8'h00))
      else $error("poll word malformed");
   AST_MASK_RD: assert property (rdReq && addr0 && !pollSh
      |=> dataOut == $past(mk))
      else $error("mask readback differs");
   AST_MASK_INT: assert property ((mk == 8'hFF)[*4] |-> !intOut)
      else $error("interrupt with all inputs masked");
   AST_INT_IDLE: assert property ((irqPin == 8'h00 && !pollSh)[*6]
      |-> !intOut)
      else $error("interrupt without request");
   AST_BUF_OE: assert property (bufSh[*2] |-> spEnOe)
      else $error("buffer pin not an output");
   AST_SPEN_LOW: assert property (spEnOe && dataOe |-> !spEnOut_n)
      else $error("buffer enable idle while driving");
   AST_DOE_SRC: assert property (dataOe |-> $past(rdReq) ||
      $past(ackStrobe) || $past(ackStrobe, 2))
      else $error("data driven without read or ack");
   AST_CAS_OE: assert property (casOut != 3'h0 |-> casOe)
      else $error("cascade code while not master");

   cover property (rdReq && pollSh);
   cover property ($rose(intOut));
   cover property (spEnOe && dataOe);
endmodule

bind pic_core pic_core_monitor mon_u (.clk(clk), .rst(rst), .cs(cs),
   .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .addr0(addr0),
   .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
   .ackStrobe(ackStrobe), .irqPin(irqPin), .casOut(casOut),
   .casOe(casOe), .spEnOut_n(spEnOut_n), .spEnOe(spEnOe),
   .intOut(intOut));

// [tb/pic_host_model.sv]
// pic_host_model: host processor driving bus accesses and ack pulses.
// assumes the core samples at rising edges; this side moves at falling.
module pic_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] dataOut,
   output logic            cs,
   output logic            wrStrobe,
   output logic            rdStrobe,
   output logic            addr0,
   output logic [7:0]      dataIn,
   output logic            ackStrobe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs = 1'b0;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      addr0 = 1'b0;
      dataIn = 8'h00;
      ackStrobe = 1'b0;
   end

   // end commands are issued per device by the caller
   task automatic wr(input logic a, input logic [7:0] v);
      @(negedge clk);
      cs <= 1'b1;
      wrStrobe <= 1'b1;
      addr0 <= a;
      dataIn <= v;
      @(negedge clk);
      cs <= 1'b0;
      wrStrobe <= 1'b0;
      dataIn <= ~v;
   endtask

   task automatic rd(input logic a, output logic [7:0] v);
      @(negedge clk);
      cs <= 1'b1;
      rdStrobe <= 1'b1;
      addr0 <= a;
      @(negedge clk);
      v = dataOut;
      cs <= 1'b0;
      rdStrobe <= 1'b0;
   endtask

   // one ack pulse of hold cycles; data taken before release
   task automatic pulse(input int hold, output logic [7:0] v);
      @(negedge clk);
      ackStrobe <= 1'b1;
      repeat (hold) @(negedge clk);
      v = dataOut;
      ackStrobe <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
endmodule

// [tb/pic_core_tb_top.sv]
// pic_core_tb_top: directed sequences of bus and ack calls on the core.
// assumes pic_pkg and the monitor are compiled; inputs move at falling edge.
module pic_core_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic       clk    = 1'b0;
   logic       rst    = 1'b1;
   logic [7:0] irqPin = 8'h00;
   logic [2:0] casIn  = 3'h0;
   logic       spEnIn = 1'b1;
   logic       cs, wrStrobe, rdStrobe, addr0, ackStrobe, dataOe;
   logic       casOe, spEnOut_n, spEnOe, intOut;
   logic [7:0] dataIn, dataOut, d, firstB;
   logic [2:0] casOut;
   int         err_count = 0;
   int         n_tests   = 0;

   always #2 clk = ~clk;

   pic_core dut_u (.clk(clk), .rst(rst), .cs(cs), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .addr0(addr0), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .ackStrobe(ackStrobe),
      .irqPin(irqPin), .casIn(casIn), .casOut(casOut), .casOe(casOe),
      .spEnIn(spEnIn), .spEnOut_n(spEnOut_n), .spEnOe(spEnOe),
      .intOut(intOut));
   pic_host_model hst (.clk(clk), .dataOut(dataOut), .cs(cs),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .addr0(addr0),
      .dataIn(dataIn), .ackStrobe(ackStrobe));

   task automatic chk(input logic [7:0] g, e, input string nm);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic r(input logic a, input logic [7:0] e, input string nm);
      hst.rd(a, d);
      chk(d, e, nm);
   endtask

   // n ack pulses; last byte compared, first kept
   task automatic ak(input int n, input logic [7:0] e);
      for (int i = 0; i < n; i++) begin
         hst.pulse(2 + i, d);
         if (i == 0)
            firstB = d;
      end
      chk(d, e, "ackbyte");
   endtask

   task automatic ci(input logic e);
      repeat (4) @(negedge clk);
      chk({7'h00, intOut}, {7'h00, e}, "intOut");
   endtask

   // drop all request pins, then raise a fresh set
   task automatic pin(input logic [7:0] v);
      irqPin <= 8'h00;
      repeat (6) @(negedge clk);
      irqPin <= v;
      repeat (6) @(negedge clk);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("[ERR] watchdog exp 0 got 1");
      conclude();
   end

   initial begin
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      hst.wr(0, 8'h13);
      hst.wr(1, 8'h40);
      hst.wr(1, 8'h01);
      r(1, 8'h00, "mask");
      hst.wr(1, 8'hFF);
      repeat (6) @(negedge clk);
      r(1, 8'hFF, "mask");
      hst.wr(1, 8'h00);
      pin(8'h28);
      hst.wr(0, 8'h0A);
      r(0, 8'h28, "irr");
      ak(2, 8'h43);
      hst.wr(0, 8'h0B);
      r(0, 8'h08, "isr");
      ci(1'b0);
      $display("test nesting done");
      hst.wr(0, 8'h20);
      r(0, 8'h00, "isr");
      ci(1'b1);
      ak(2, 8'h45);
      hst.wr(1, 8'h02);
      pin(8'h0A);
      ci(1'b1);
      ak(2, 8'h43);
      hst.wr(0, 8'h65);
      r(0, 8'h08, "isr");
      hst.wr(0, 8'h63);
      hst.wr(1, 8'h00);
      $display("test end of service done");
      pin(8'h40);
      hst.wr(0, 8'h0C);
      r(0, 8'h86, "poll");
      hst.wr(0, 8'h0B);
      r(0, 8'h40, "isr");
      hst.wr(0, 8'h66);
      pin(8'h00);
      hst.wr(0, 8'h0C);
      r(0, 8'h00, "poll");
      $display("test poll done");
      hst.wr(0, 8'hC4);
      pin(8'h44);
      hst.wr(0, 8'h0C);
      r(0, 8'h86, "poll");
      hst.wr(0, 8'h66);
      hst.wr(0, 8'h0C);
      r(0, 8'h82, "poll");
      hst.wr(0, 8'hE2);
      hst.wr(0, 8'hC7);
      $display("test set priority done");
      pin(8'h08);
      ak(2, 8'h43);
      hst.wr(1, 8'h08);
      hst.wr(0, 8'h68);
      pin(8'h20);
      ci(1'b1);
      hst.wr(0, 8'h20);
      r(0, 8'h08, "isr");
      hst.wr(0, 8'h48);
      ci(1'b0);
      hst.wr(0, 8'hA0);
      $display("test special mask done");
      hst.wr(0, 8'h13);
      hst.wr(1, 8'h40);
      hst.wr(1, 8'h03);
      r(1, 8'h00, "mask");
      hst.wr(0, 8'h80);
      pin(8'h10);
      ak(2, 8'h44);
      hst.wr(0, 8'h0B);
      r(0, 8'h00, "isr");
      pin(8'h24);
      hst.wr(0, 8'h0C);
      r(0, 8'h85, "poll");
      hst.wr(0, 8'h65);
      hst.wr(0, 8'h00);
      $display("test auto end done");
      hst.wr(0, 8'h1A);
      hst.wr(1, 8'h40);
      pin(8'h01);
      ak(3, 8'h40);
      chk(firstB, 8'hCD, "callbyte");
      hst.wr(0, 8'h0B);
      r(0, 8'h01, "isr");
      hst.wr(0, 8'h20);
      $display("test call mode done");
      hst.wr(0, 8'h11);
      hst.wr(1, 8'h40);
      hst.wr(1, 8'h08);
      hst.wr(1, 8'h1D);
      pin(8'h08);
      chk({7'h00, spEnOe}, 8'h01, "spEnOe");
      hst.pulse(2, d);
      chk({5'h00, casOut}, 8'h03, "casOut");
      hst.pulse(2, d);
      pin(8'h08);
      ci(1'b1);
      hst.wr(0, 8'h63);
      spEnIn <= 1'b0;
      casIn <= 3'h2;
      hst.wr(0, 8'h11);
      hst.wr(1, 8'h40);
      hst.wr(1, 8'h02);
      hst.wr(1, 8'h01);
      pin(8'h10);
      ak(2, 8'h44);
      hst.wr(0, 8'h0B);
      r(0, 8'h10, "isr");
      hst.wr(0, 8'h64);
      r(0, 8'h00, "isr");
      $display("test cascade done");
      conclude();
   end
endmodule
